// *** iot_pkg.sv ***
//
// Purpose : constants for the internal oscillator tuning block
// Assumes : apb slave, 32-bit data, one aligned word per register
// Notes   : offsets are byte addresses
//
package iot_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] OSC_TUNING_OFFSET = 8'h00; // oscillator_tuning
    localparam logic [7:0] OSC_STATUS_OFFSET = 8'h04; // clock status

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int         LF_SEL_BIT     = 7;      // low_freq_source_select
    localparam int         PLL_EN_BIT     = 6;      // pll_enable
    localparam int         UNUSED_BIT     = 5;      // reads zero
    localparam int         TRIM_MSB       = 4;      // frequency_trim top
    localparam int         TRIM_W         = 5;      // frequency_trim width
    localparam logic [7:0] TUNING_RESET   = 8'h00;  // power-on value
    localparam logic [7:0] TUNING_WMASK   = 8'hDF;  // implemented bits

    // ****************************************************************
    // clocking
    // ****************************************************************
    localparam int         FAST_DIV       = 256;    // 8 MHz to 31.25 kHz
    localparam int         FAST_CNT_W     = 8;      // divider counter width

endpackage

// *** iot_lf_if.sv ***
//
// Purpose : carries low-frequency clock selection between modules
// Assumes : single clock domain
// Notes   : enables are one-cycle pulses
//
`timescale 1ns/1ps
interface iot_lf_if;
    logic fast_tick;   // one pulse per fast oscillator cycle
    logic rc_tick;     // one pulse per rc oscillator cycle
    logic sel_fast;    // low_freq_source_select
    logic lf_tick;     // resulting low-speed enable

    modport gen
    (
        input  fast_tick,
        input  rc_tick,
        input  sel_fast,
        output lf_tick
    );
    modport user
    (
        output fast_tick,
        output rc_tick,
        output sel_fast,
        input  lf_tick
    );
endinterface

// *** iot_lf_gen.sv ***
//
// Purpose : derives the low-speed clock enable from either source
// Assumes : input ticks are synchronous one-cycle pulses
// Notes   : divider runs free so a switch takes effect at once
//
`timescale 1ns/1ps
module iot_lf_gen
(
    input  wire logic i_clk,     // system clock
    input  wire logic i_resetn,  // async reset, active low
    iot_lf_if.gen     lf         // source ticks and result
);

    logic [iot_pkg::FAST_CNT_W-1:0] div_reg;  // fast divider count
    logic                           div_wrap; // divider terminal count

    // divide-by-256 terminal count
    assign div_wrap = lf.fast_tick
                      && (div_reg == iot_pkg::FAST_CNT_W'(iot_pkg::FAST_DIV-1));

    // source selection for the low-speed enable
    assign lf.lf_tick = lf.sel_fast ? div_wrap
                                    : lf.rc_tick;

    // free-running divider of the fast oscillator ticks
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            div_reg <= '0;
        else if (lf.fast_tick)
            div_reg <= div_reg + 1'b1;
    end

    // elaboration check: the counter must wrap exactly at the ratio
    if (iot_pkg::FAST_DIV != (1 << iot_pkg::FAST_CNT_W))
    begin
        $error("divider width does not match divide ratio");
    end

    // fast path fires only on a counted tick at the wrap
    AST_DIV_256: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        lf.sel_fast && lf.lf_tick |-> lf.fast_tick && div_reg == 8'hFF)
        else $error("fast path tick not at divide-by-256 wrap");
    AST_RC_DIRECT: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        !lf.sel_fast |-> lf.lf_tick == lf.rc_tick)
        else $error("rc path not passed straight through");

endmodule

// *** iot_osc_tuning.sv ***
//
// Purpose : oscillator tuning register with apb access and clock control
// Assumes : oscillator ticks arrive as pins and are resynchronised
// Notes   : trim is passed out for the analog oscillator; pll gated
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module iot_osc_tuning
#(
    parameter bit PLL_AVAILABLE = 1'b1  // configuration offers the pll
)
(
    input  wire logic        i_clk,          // 25 MHz system clock
    input  wire logic        i_resetn,       // async reset, active low
    input  wire logic        i_psel,         // apb select
    input  wire logic        i_penable,      // apb enable
    input  wire logic        i_pwrite,       // apb write
    input  wire logic [7:0]  i_paddr,        // apb byte address
    input  wire logic [31:0] i_pwdata,       // apb write data
    output logic      [31:0] o_prdata,       // apb read data
    output logic             o_pready,       // apb ready
    output logic             o_pslverr,      // apb error
    input  wire logic        i_fast_tick,    // fast oscillator tick pin
    input  wire logic        i_rc_tick,      // rc oscillator tick pin
    input  wire logic        i_fast_at_4_8,  // fast osc at 4 or 8 MHz
    output logic             o_lf_tick,      // low-speed clock enable
    output logic             o_pll_on,       // multiplier enable
    output logic      [4:0]  o_frequency_trim // signed trim to oscillator
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] fast_sync_reg;  // fast tick sync chain
    logic [2:0] rc_sync_reg;    // rc tick sync chain
    logic [2:0] rng_sync_reg;   // range sync chain
    logic       fast_lvl_reg;   // accepted fast level
    logic       rc_lvl_reg;     // accepted rc level
    logic       rng_lvl_reg;    // accepted range level
    logic       fast_pulse;     // fast rising edge pulse
    logic       rc_pulse;       // rc rising edge pulse

    // three stages, change accepted when last two agree
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            fast_sync_reg <= 3'h0;
            rc_sync_reg   <= 3'h0;
            rng_sync_reg  <= 3'h0;
            fast_lvl_reg  <= 1'b0;
            rc_lvl_reg    <= 1'b0;
            rng_lvl_reg   <= 1'b0;
        end
        else
        begin
            fast_sync_reg <= {fast_sync_reg[1:0], i_fast_tick};
            rc_sync_reg   <= {rc_sync_reg[1:0], i_rc_tick};
            rng_sync_reg  <= {rng_sync_reg[1:0], i_fast_at_4_8};
            if (fast_sync_reg[1] == fast_sync_reg[2])
                fast_lvl_reg <= fast_sync_reg[2];
            if (rc_sync_reg[1] == rc_sync_reg[2])
                rc_lvl_reg <= rc_sync_reg[2];
            if (rng_sync_reg[1] == rng_sync_reg[2])
                rng_lvl_reg <= rng_sync_reg[2];
        end
    end

    // rising edges of the accepted levels
    assign fast_pulse = (fast_sync_reg[2] == fast_sync_reg[1])
                        && fast_sync_reg[2] && !fast_lvl_reg;
    assign rc_pulse   = (rc_sync_reg[2] == rc_sync_reg[1])
                        && rc_sync_reg[2] && !rc_lvl_reg;

    // ****************************************************************
    // apb register access
    // ****************************************************************
    logic [7:0] tuning_reg;   // oscillator_tuning storage
    logic [7:0] tuning_next;  // next value on write
    logic [7:0] tuning_rd;    // read view of the register
    logic [7:0] status_rd;    // read view of status
    logic       hit_tuning;   // tuning address decoded
    logic       hit_status;   // status address decoded
    logic       apb_access;   // access phase
    logic       wr_tuning;    // write strobe

    assign apb_access = i_psel && i_penable;
    assign hit_tuning = (i_paddr == iot_pkg::OSC_TUNING_OFFSET);
    assign hit_status = (i_paddr == iot_pkg::OSC_STATUS_OFFSET);
    assign wr_tuning  = apb_access && i_pwrite && hit_tuning;
    assign o_pready   = 1'b1;                             // zero wait
    assign o_pslverr  = apb_access && !(hit_tuning || hit_status);

    // only implemented bits are stored; pll bit kept only when present
    assign tuning_next = i_pwdata[7:0] & iot_pkg::TUNING_WMASK
                         & {1'b1, PLL_AVAILABLE, 6'h3F};

    // bit five and an absent pll bit read zero
    assign tuning_rd = tuning_reg & iot_pkg::TUNING_WMASK;
    assign status_rd = {6'h00, rng_lvl_reg, o_pll_on};

    // register storage, reset to zero
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            tuning_reg <= iot_pkg::TUNING_RESET;
        else if (wr_tuning)
            tuning_reg <= tuning_next;
    end

    // read data registered from the setup phase
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_prdata <= 32'h0000_0000;
        else if (i_psel && !i_penable && !i_pwrite)
            o_prdata <= hit_tuning ? {24'h000000, tuning_rd}
                      : hit_status ? {24'h000000, status_rd}
                      : 32'h0000_0000;
    end

    // ****************************************************************
    // clock control outputs
    // ****************************************************************
    logic pll_next;  // gated multiplier request

    // multiplier only at 4 or 8 MHz and only if present
    assign pll_next = tuning_reg[iot_pkg::PLL_EN_BIT] && rng_lvl_reg
                      && PLL_AVAILABLE;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_pll_on         <= 1'b0;
            o_frequency_trim <= 5'h00;
        end
        else
        begin
            o_pll_on         <= pll_next;
            // signed code straight to oscillator; 0 centre, 0F max
            o_frequency_trim <= tuning_reg[iot_pkg::TRIM_MSB:0];
        end
    end

    // ****************************************************************
    // low-speed clock generation
    // ****************************************************************
    iot_lf_if lf_bus ();

    assign lf_bus.fast_tick = fast_pulse;
    assign lf_bus.rc_tick   = rc_pulse;
    assign lf_bus.sel_fast  = tuning_reg[iot_pkg::LF_SEL_BIT];
    assign o_lf_tick        = lf_bus.lf_tick;

    iot_lf_gen u_lf_gen
    (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .lf       (lf_bus.gen)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    // register access: read view, unimplemented bits and storage
    AST_BIT5_ZERO: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_psel && !i_penable && !i_pwrite && hit_tuning
        |=> o_prdata[iot_pkg::UNUSED_BIT] == 1'b0)
        else $error("unimplemented bit reads non-zero");
    AST_READ_BACK: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        i_psel && !i_penable && !i_pwrite && hit_tuning
        |=> o_prdata == {24'h000000, $past(tuning_reg)})
        else $error("read data differs from stored value");
    AST_PLL_ABSENT: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        !PLL_AVAILABLE |-> tuning_rd[iot_pkg::PLL_EN_BIT] == 1'b0)
        else $error("absent pll bit reads non-zero");
    AST_WRITE_BACK: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        wr_tuning |=> tuning_reg[4:0] == $past(i_pwdata[4:0])
                      && tuning_reg[7] == $past(i_pwdata[7]))
        else $error("written value not held");
    AST_HOLD: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        !wr_tuning |=> $stable(tuning_reg))
        else $error("register changed without write");

    // clock control: multiplier gating and trim output
    AST_PLL_GATED: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        o_pll_on |-> $past(rng_lvl_reg)
                     && $past(tuning_reg[iot_pkg::PLL_EN_BIT]))
        else $error("pll on outside allowed range or when disabled");
    AST_PLL_FOLLOW: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        rng_lvl_reg && tuning_reg[iot_pkg::PLL_EN_BIT] && PLL_AVAILABLE
        |=> o_pll_on)
        else $error("pll not enabled when requested");
    AST_TRIM_OUT: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        wr_tuning |-> ##2 o_frequency_trim == $past(i_pwdata[4:0], 2))
        else $error("trim output does not follow register");

    // low-speed enable: source choice and one-cycle width
    AST_LF_SEL: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        !tuning_reg[iot_pkg::LF_SEL_BIT] |-> o_lf_tick == rc_pulse)
        else $error("rc path not selected");
    AST_LF_PULSE: assert property (
        @(posedge i_clk) disable iff (!i_resetn)
        o_lf_tick && !wr_tuning |=> !o_lf_tick)
        else $error("low-speed enable longer than one cycle");

    COV_WRITE: cover property (@(posedge i_clk) wr_tuning);
    COV_FAST_LF: cover property (@(posedge i_clk)
        tuning_reg[iot_pkg::LF_SEL_BIT] && o_lf_tick);
    COV_PLL: cover property (@(posedge i_clk) o_pll_on);
    COV_ERR: cover property (@(posedge i_clk) o_pslverr);

endmodule

// *** internal_osc_tuning_test.sv ***
//
// Purpose : self-checking bench for the oscillator tuning block
// Assumes : zero-wait apb slave, oscillator ticks five cycles apart
// Notes   : second instance is built without the pll option
//
`timescale 1ns/1ps
module internal_osc_tuning_test;
    // ****************************************************************
    // stimulus and observation signals
    // ****************************************************************
    logic        i_clk       = 1'b0;  // 25 MHz clock
    logic        i_resetn    = 1'b0;  // async reset, active low
    logic        i_psel      = 1'b0;  // apb select
    logic        i_penable   = 1'b0;  // apb enable
    logic        i_pwrite    = 1'b0;  // apb direction
    logic [7:0]  i_paddr     = 8'h00; // apb address
    logic [31:0] i_pwdata    = 32'h0; // apb write data
    logic        i_fast_tick = 1'b0;  // fast oscillator pin
    logic        i_rc_tick   = 1'b0;  // rc oscillator pin
    logic        range_ok    = 1'b0;  // fast osc at 4 or 8 MHz
    logic [31:0] o_prdata;            // read data
    logic [31:0] prdata_nopll;        // read data, no-pll instance
    logic        o_pready;            // apb ready
    logic        o_pslverr;           // apb error
    logic        o_lf_tick;           // low-speed enable
    logic        o_pll_on;            // multiplier enable
    logic [4:0]  o_frequency_trim;    // trim to oscillator
    logic [31:0] rdata;               // last read data
    logic [31:0] rdata2;              // last read data, no-pll
    logic        err;                 // last slave error
    logic [7:0]  model;               // model of the register
    logic [31:0] d;                   // next write value
    int          n_mismatch  = 0;     // mismatch count
    int          total_checks = 0;    // comparison count
    int          lf_count    = 0;     // low-speed pulses seen
    int          base;                // count snapshot

    iot_osc_tuning u_iot_osc_tuning (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_fast_tick(i_fast_tick), .i_rc_tick(i_rc_tick),
        .i_fast_at_4_8(range_ok), .o_lf_tick(o_lf_tick),
        .o_pll_on(o_pll_on), .o_frequency_trim(o_frequency_trim));

    iot_osc_tuning #(.PLL_AVAILABLE(1'b0)) u_iot_osc_tuning_nopll (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(prdata_nopll), .o_pready(),
        .o_pslverr(), .i_fast_tick(i_fast_tick), .i_rc_tick(i_rc_tick),
        .i_fast_at_4_8(range_ok), .o_lf_tick(), .o_pll_on(),
        .o_frequency_trim());

    // clock and low-speed pulse counter
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk)
        if (o_lf_tick === 1'b1)
            lf_count <= lf_count + 1;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        total_checks++;
        if (seen !== exp)
        begin
            $display("Error at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
            n_mismatch++;
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel    <= 1'b1;
        i_pwrite  <= wr;
        i_paddr   <= a;
        i_pwdata  <= v;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_pready !== 1'b1 && n < 16);
        rdata     = o_prdata;
        rdata2    = prdata_nopll;
        err       = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        if (o_pready !== 1'b1)
        begin
            $display("Error at %0t: apb timeout", $time);
            n_mismatch++;
            give_verdict();
        end
    endtask

    // n pin pulses, two cycles high and three low
    task pulse(input logic fast, input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            i_fast_tick <= fast;
            i_rc_tick   <= ~fast;
            repeat (2) @(posedge i_clk);
            i_fast_tick <= 1'b0;
            i_rc_tick   <= 1'b0;
            repeat (2) @(posedge i_clk);
        end
    endtask

    // calibration step: move the signed trim, keep the other bits
    task tune(input int step);
        int t;
        t = int'($signed(model[4:0])) + step;
        if (t > 15)
            t = 15;
        if (t < -16)
            t = -16;
        model[4:0] = t[4:0];
        apb(1'b1, 8'h00, {24'h0, model});
        repeat (3) @(posedge i_clk);
        check(o_frequency_trim, model[4:0], "tuned trim");
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h67811FA1));
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, 32'h0, "reset value");
        check({o_pll_on, o_frequency_trim}, 32'h0, "reset outputs");
        $display("test reset done");
        for (int i = 0; i < 12; i++)
        begin
            case (i)
                0: d = 32'h0000_00FF;
                1: d = 32'h0000_0020;
                2: d = 32'h0000_0040;
                3: d = 32'h0000_0010;
                default: d = $urandom;
            endcase
            range_ok <= (i % 3 != 2);
            model = d[7:0] & 8'hDF;
            apb(1'b1, 8'h00, d);
            check(err, 1'b0, "write error");
            repeat (3) @(posedge i_clk);
            check(o_frequency_trim, model[4:0], "trim");
            check(o_pll_on, model[6] & range_ok, "pll on");
            apb(1'b0, 8'h00, 32'h0);
            check(rdata, {24'h0, model}, "readback");
            check(rdata2, {24'h0, model & 8'hBF}, "no pll");
            apb(1'b0, 8'h04, 32'h0);
            d = {30'h0, range_ok, model[6] & range_ok};
            check(rdata, d, "status");
        end
        $display("test register done");
        apb(1'b1, 8'h08, 32'h0000_00FF);
        check(err, 1'b1, "unmapped write error");
        apb(1'b0, 8'h08, 32'h0);
        check(err, 1'b1, "unmapped read error");
        check(rdata, 32'h0, "unmapped read");
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, {24'h0, model}, "unmapped write ignored");
        $display("test unmapped done");
        apb(1'b1, 8'h00, 32'h0);
        repeat (8) @(posedge i_clk);
        base = lf_count;
        pulse(1'b0, 10);
        repeat (8) @(posedge i_clk);
        check(lf_count - base, 10, "rc source pulses");
        apb(1'b1, 8'h00, 32'h0000_0080);
        repeat (8) @(posedge i_clk);
        base = lf_count;
        pulse(1'b1, 512);
        repeat (8) @(posedge i_clk);
        check(lf_count - base, 2, "fast source divided");
        base = lf_count;
        pulse(1'b0, 5);
        repeat (8) @(posedge i_clk);
        check(lf_count - base, 0, "rc ignored when fast");
        $display("test low speed done");
        model = 8'h80;
        tune(-1);
        check(o_frequency_trim, 5'h1F, "just below centre");
        tune(1);
        base = 250 + $urandom_range(8, 1);
        tune((base > 250) ? -1 : 1);
        base = 250 - $urandom_range(80, 60);
        repeat (20) tune((base < 200) ? 1 : -1);
        check(o_frequency_trim, 5'h0F, "maximum trim");
        repeat (40) tune(-1);
        check(o_frequency_trim, 5'h10, "minimum trim");
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, {24'h0, model}, "tuned readback");
        $display("test calibration done");
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        check(rdata, 32'h0, "reset in run");
        check({o_pll_on, o_frequency_trim}, 32'h0, "reset outputs 2");
        $display("test reset in run done");
        give_verdict();
    end
endmodule
